// ### incr_exec_pkg.sv
// Constants and types shared by the interrupt-enable and increment execution unit
package incr_exec_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_GLOBAL_IRQ_UNMASK = 8'h9f;
    localparam logic [7:0] OPC_INC_DIRECT        = 8'h20;
    localparam logic [7:0] OPC_INC_POINTER       = 8'h21;
    localparam logic [7:0] OPC_PAIR_DIRECT       = 8'ha0;
    localparam logic [7:0] OPC_PAIR_POINTER      = 8'ha1;
    localparam logic [3:0] NIB_INC_WORKING       = 4'he;
    localparam logic [3:0] NIB_WORKING_ESCAPE    = 4'he;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INTERRUPT_GATE_MASK = 8'hfb;
    localparam logic [7:0] ADDR_FLAGS               = 8'hfc;
    localparam int         IMR_GLOBAL_BIT           = 7;
    localparam int         FLAG_Z_BIT               = 6;
    localparam int         FLAG_S_BIT               = 5;
    localparam int         FLAG_V_BIT               = 4;
    localparam logic [7:0] IMR_RESET                = 8'h00;
    localparam logic [7:0] FLAGS_RESET              = 8'h00;

    // ------------------------------------------------------------
    // Cycle counts per instruction
    // ------------------------------------------------------------
    localparam logic [3:0] CYCLES_UNMASK = 4'd6;
    localparam logic [3:0] CYCLES_INC    = 4'd6;
    localparam logic [3:0] CYCLES_PAIR   = 4'd10;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'b0000001,
        ST_PTR      = 7'b0000010,
        ST_READ_HI  = 7'b0000100,
        ST_READ_LO  = 7'b0001000,
        ST_WRITE_HI = 7'b0010000,
        ST_HOLD     = 7'b0100000,
        ST_SPARE    = 7'b1000000
    } state_type;

endpackage : incr_exec_pkg

// ### operand_resolver.sv
// Maps an operand byte to a register-file address, expanding working-register forms
`timescale 1ns/100ps
`default_nettype none
module operand_resolver
    import incr_exec_pkg::*;
(
    // Operand in
    input  wire logic [7:0] operand_i,
    input  wire logic [3:0] rp_i,
    // Address out
    output logic      [7:0] addr_o
);

    always_comb begin
        if (operand_i[7:4] == NIB_WORKING_ESCAPE) begin
            addr_o = {rp_i, operand_i[3:0]};
        end else begin
            addr_o = operand_i;
        end
    end

endmodule : operand_resolver
`default_nettype wire

// ### plus_one_unit.sv
// Byte or word increment with zero, sign and overflow results
`timescale 1ns/100ps
`default_nettype none
module plus_one_unit (
    // Operand
    input  wire logic [15:0] value_i,
    input  wire logic        word_i,
    // Result
    output logic      [15:0] result_o,
    output logic             zero_o,
    output logic             sign_o,
    output logic             ovf_o
);

    always_comb begin
        result_o = value_i + 16'h0001;
        if (word_i) begin
            zero_o = (result_o == 16'h0000);
            sign_o = result_o[15];
            ovf_o  = (value_i == 16'h7fff);
        end else begin
            zero_o = (result_o[7:0] == 8'h00);
            sign_o = result_o[7];
            ovf_o  = (value_i[7:0] == 8'h7f);
        end
    end

endmodule : plus_one_unit
`default_nettype wire

// ### int_enable_and_increment_exec.sv
// Execution unit for global interrupt unmask, byte increment and pair increment
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module int_enable_and_increment_exec
    import incr_exec_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Instruction issue
    input  wire logic       start_i,
    input  wire logic [7:0] opcode_i,
    input  wire logic [7:0] operand_i,
    input  wire logic [3:0] rp_i,
    output logic            accept_o,
    output logic            busy_o,
    output logic            done_o,
    // Register file port
    output logic      [7:0] rf_addr_o,
    output logic            rf_re_o,
    output logic            rf_we_o,
    output logic      [7:0] rf_wdata_o,
    input  wire logic [7:0] rf_rdata_i,
    // Software register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_we_i,
    input  wire logic       reg_re_i,
    output logic      [7:0] reg_rdata_o,
    // Control register views
    output logic      [7:0] imr_o,
    output logic      [7:0] flags_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    state_type   state_ff;
    logic [3:0]  cnt_ff;
    logic [3:0]  last_ff;
    logic        word_ff;
    logic        ptr_ff;
    logic [7:0]  addr_ff;
    logic [7:0]  hi_ff;
    logic [7:0]  res_hi_ff;
    logic [7:0]  imr_ff;
    logic [7:0]  flags_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  rf_addr_ff;
    logic        rf_re_ff;
    logic        rf_we_ff;
    logic [7:0]  rf_wdata_ff;
    logic        data_ok_ff;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic        is_unmask;
    logic        is_inc_working;
    logic        is_inc_direct;
    logic        is_inc_pointer;
    logic        is_pair_direct;
    logic        is_pair_pointer;
    logic        is_word;
    logic        is_pointer;
    logic        known;
    logic [7:0]  operand_sel;
    logic [7:0]  operand_addr;
    logic [7:0]  ptr_addr;
    logic [15:0] inc_value;
    logic [15:0] inc_result;
    logic        inc_zero;
    logic        inc_sign;
    logic        inc_ovf;
    logic        flag_update;
    logic        unmask_fire;

    always_comb begin
        is_unmask       = (opcode_i == OPC_GLOBAL_IRQ_UNMASK);
        is_inc_working  = (opcode_i[3:0] == NIB_INC_WORKING);
        is_inc_direct   = (opcode_i == OPC_INC_DIRECT);
        is_inc_pointer  = (opcode_i == OPC_INC_POINTER);
        is_pair_direct  = (opcode_i == OPC_PAIR_DIRECT);
        is_pair_pointer = (opcode_i == OPC_PAIR_POINTER);
        is_word         = is_pair_direct | is_pair_pointer;
        is_pointer      = is_inc_pointer | is_pair_pointer;
        known           = is_unmask | is_inc_working | is_inc_direct | is_inc_pointer | is_word;
        // Working-register opcode form reuses the escape path of the resolver
        operand_sel     = is_inc_working ? {NIB_WORKING_ESCAPE, opcode_i[7:4]} : operand_i;
    end

    assign accept_o    = start_i & (state_ff == ST_IDLE) & known;
    assign busy_o      = (state_ff != ST_IDLE);
    assign done_o      = (state_ff == ST_HOLD) & (cnt_ff == last_ff);
    assign flag_update = (state_ff == ST_READ_LO) & data_ok_ff;
    assign unmask_fire = accept_o & is_unmask;
    assign ptr_addr    = word_ff ? {rf_rdata_i[7:1], 1'b0} : rf_rdata_i;
    assign inc_value   = word_ff ? {hi_ff, rf_rdata_i} : {8'h00, rf_rdata_i};

    operand_resolver u_resolver (
        .operand_i (operand_sel),
        .rp_i      (rp_i),
        .addr_o    (operand_addr)
    );

    plus_one_unit u_plus_one (
        .value_i  (inc_value),
        .word_i   (word_ff),
        .result_o (inc_result),
        .zero_o   (inc_zero),
        .sign_o   (inc_sign),
        .ovf_o    (inc_ovf)
    );

    // ------------------------------------------------------------
    // Sequencer and register-file access
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff    <= ST_IDLE;
            last_ff     <= 4'h0;
            word_ff     <= 1'b0;
            ptr_ff      <= 1'b0;
            addr_ff     <= 8'h00;
            hi_ff       <= 8'h00;
            res_hi_ff   <= 8'h00;
            rf_addr_ff  <= 8'h00;
            rf_re_ff    <= 1'b0;
            rf_we_ff    <= 1'b0;
            rf_wdata_ff <= 8'h00;
        end else begin
            rf_re_ff <= 1'b0;
            rf_we_ff <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (accept_o) begin
                        word_ff <= is_word;
                        ptr_ff  <= is_pointer;
                        if (is_unmask) begin
                            last_ff  <= CYCLES_UNMASK - 4'd1;
                            state_ff <= ST_HOLD;
                        end else begin
                            last_ff    <= is_word ? CYCLES_PAIR - 4'd1
                                                  : CYCLES_INC - 4'd1;
                            rf_re_ff   <= 1'b1;
                            addr_ff    <= is_word ? {operand_addr[7:1], 1'b0} : operand_addr;
                            rf_addr_ff <= (is_word && !is_pointer) ? {operand_addr[7:1], 1'b0}
                                                                   : operand_addr;
                            if (is_pointer) begin
                                state_ff <= ST_PTR;
                            end else if (is_word) begin
                                state_ff <= ST_READ_HI;
                            end else begin
                                state_ff <= ST_READ_LO;
                            end
                        end
                    end
                end
                // Read states wait in place until the strobed data arrive
                ST_PTR: begin
                    if (data_ok_ff) begin
                        addr_ff    <= ptr_addr;
                        rf_addr_ff <= ptr_addr;
                        rf_re_ff   <= 1'b1;
                        state_ff   <= word_ff ? ST_READ_HI : ST_READ_LO;
                    end
                end
                ST_READ_HI: begin
                    if (data_ok_ff) begin
                        hi_ff      <= rf_rdata_i;
                        rf_addr_ff <= {addr_ff[7:1], 1'b1};
                        rf_re_ff   <= 1'b1;
                        state_ff   <= ST_READ_LO;
                    end
                end
                ST_READ_LO: begin
                    if (data_ok_ff) begin
                        rf_addr_ff  <= word_ff ? {addr_ff[7:1], 1'b1} : addr_ff;
                        rf_wdata_ff <= inc_result[7:0];
                        rf_we_ff    <= 1'b1;
                        res_hi_ff   <= inc_result[15:8];
                        state_ff    <= word_ff ? ST_WRITE_HI : ST_HOLD;
                    end
                end
                ST_WRITE_HI: begin
                    rf_addr_ff  <= addr_ff;
                    rf_wdata_ff <= res_hi_ff;
                    rf_we_ff    <= 1'b1;
                    state_ff    <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (cnt_ff == last_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read-data tracker
    // ------------------------------------------------------------
    // The register file answers one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_ok_ff <= 1'b0;
        end else begin
            data_ok_ff <= rf_re_ff;
        end
    end

    // ------------------------------------------------------------
    // Cycle counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 4'h0;
        end else if (accept_o) begin
            cnt_ff <= 4'h1;
        end else if (state_ff != ST_IDLE) begin
            cnt_ff <= cnt_ff + 4'h1;
        end else begin
            cnt_ff <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt gate mask
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            imr_ff <= IMR_RESET;
        end else begin
            if (reg_we_i && reg_addr_i == ADDR_INTERRUPT_GATE_MASK) begin
                imr_ff <= reg_wdata_i;
            end
            if (unmask_fire) begin
                // Level bits keep the software value of this cycle
                imr_ff[IMR_GLOBAL_BIT] <= 1'b1;
                if (!(reg_we_i && reg_addr_i == ADDR_INTERRUPT_GATE_MASK)) begin
                    imr_ff[IMR_GLOBAL_BIT-1:0] <= imr_ff[IMR_GLOBAL_BIT-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_ff <= FLAGS_RESET;
        end else begin
            if (reg_we_i && reg_addr_i == ADDR_FLAGS) begin
                flags_ff <= reg_wdata_i;
            end
            // Only Z, S, V change; hardware update wins over a same-cycle write
            if (flag_update) begin
                flags_ff[FLAG_Z_BIT] <= inc_zero;
                flags_ff[FLAG_S_BIT] <= inc_sign;
                flags_ff[FLAG_V_BIT] <= inc_ovf;
            end
        end
    end

    // ------------------------------------------------------------
    // Software read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 8'h00;
        end else if (reg_re_i) begin
            if (reg_addr_i == ADDR_INTERRUPT_GATE_MASK) begin
                rdata_ff <= imr_ff;
            end else if (reg_addr_i == ADDR_FLAGS) begin
                rdata_ff <= flags_ff;
            end else begin
                rdata_ff <= 8'h00;
            end
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign rf_addr_o   = rf_addr_ff;
    assign rf_re_o     = rf_re_ff;
    assign rf_we_o     = rf_we_ff;
    assign rf_wdata_o  = rf_wdata_ff;
    assign imr_o       = imr_ff;
    assign flags_o     = flags_ff;

endmodule : int_enable_and_increment_exec
`default_nettype wire

// ### int_enable_and_increment_exec_sva.sv
// Concurrent checks for the unmask and increment execution unit
`timescale 1ns/100ps
`default_nettype none
module int_enable_and_increment_exec_sva
    import incr_exec_pkg::*;
(
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // Instruction issue
    input wire logic       accept_o,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] operand_i,
    input wire logic [3:0] rp_i,
    input wire logic       busy_o,
    input wire logic       done_o,
    // Register file and views
    input wire logic [7:0] rf_addr_o,
    input wire logic       rf_re_o,
    input wire logic       rf_we_o,
    input wire logic [7:0] rf_wdata_o,
    input wire logic [7:0] rf_rdata_i,
    input wire logic       reg_we_i,
    input wire logic [7:0] imr_o,
    input wire logic [7:0] flags_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       unmask;
    logic       pair;
    logic       short_op;
    logic       mem_op;
    logic [4:0] keep_bits;
    logic [7:0] esc_addr;
    logic [7:0] dir_addr;
    logic [7:0] exp_addr;
    assign unmask    = accept_o && opcode_i == OPC_GLOBAL_IRQ_UNMASK;
    assign pair      = accept_o && (opcode_i == OPC_PAIR_DIRECT || opcode_i == OPC_PAIR_POINTER);
    assign short_op  = accept_o && !pair;
    assign mem_op    = accept_o && (opcode_i inside {OPC_INC_DIRECT, OPC_INC_POINTER,
                                                      OPC_PAIR_DIRECT, OPC_PAIR_POINTER});
    assign keep_bits = {flags_o[7], flags_o[3:0]};
    assign esc_addr  = {rp_i, opcode_i[7:4]};
    assign dir_addr  = (operand_i[7:4] == NIB_WORKING_ESCAPE) ? {rp_i, operand_i[3:0]} : operand_i;
    // A direct pair always starts at the even register
    assign exp_addr  = (opcode_i == OPC_PAIR_DIRECT) ? {dir_addr[7:1], 1'b0} : dir_addr;
    // ------------------------------------------------------------
    // Assertions and cover points
    // ------------------------------------------------------------
    a_unmask_sets_global: assert property (unmask |=> imr_o[IMR_GLOBAL_BIT])
        else $error("global enable not set");
    a_unmask_keeps_levels: assert property (unmask && !reg_we_i |=> imr_o[6:0] == $past(imr_o[6:0]))
        else $error("level mask bits changed");
    a_unmask_keeps_flags: assert property (unmask && !reg_we_i |=> $stable(flags_o))
        else $error("flags changed by unmask");
    a_short_done_six: assert property (short_op |=> !done_o [*4] ##1 done_o)
        else $error("six cycle count broken");
    a_pair_done_ten: assert property (pair |=> !done_o [*8] ##1 done_o)
        else $error("ten cycle count broken");
    a_busy_span: assert property (short_op |=> busy_o [*5] ##1 !busy_o)
        else $error("busy span wrong");
    a_keep_other_flags: assert property (busy_o && !reg_we_i |=> $stable(keep_bits))
        else $error("carry, half or decimal flag changed");
    a_working_addr: assert property (accept_o && opcode_i[3:0] == NIB_INC_WORKING
        |=> rf_re_o && rf_addr_o == $past(esc_addr)) else $error("working register address wrong");
    a_escape_addr: assert property (mem_op |=> rf_re_o && rf_addr_o == $past(exp_addr))
        else $error("operand address wrong");
    a_inc_result: assert property (accept_o && opcode_i == OPC_INC_DIRECT
        |-> ##3 rf_we_o && rf_wdata_o == $past(rf_rdata_i) + 8'h01) else $error("sum wrong");
    c_unmask: cover property (unmask);
    c_pair: cover property (pair);
    c_pointer: cover property (accept_o && opcode_i == OPC_INC_POINTER);
endmodule : int_enable_and_increment_exec_sva

bind int_enable_and_increment_exec int_enable_and_increment_exec_sva u_sva (
    .clk_i, .rst_n_i, .accept_o, .opcode_i, .operand_i, .rp_i, .busy_o, .done_o,
    .rf_addr_o, .rf_re_o, .rf_we_o, .rf_wdata_o, .rf_rdata_i, .reg_we_i, .imr_o, .flags_o
);
`default_nettype wire

// ### tb_int_enable_and_increment_exec.sv
// Self-checking bench for the unmask and increment execution unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module tb_int_enable_and_increment_exec
    import incr_exec_pkg::*;
;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       start_i = 1'b0;
    logic [7:0] opcode_i = 8'h00;
    logic [7:0] operand_i = 8'h00;
    logic [3:0] rp_i = 4'h0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_we_i = 1'b0;
    logic       reg_re_i = 1'b0;
    logic [7:0] rf_rdata_i = 8'h00;
    logic       accept_o, busy_o, done_o, rf_re_o, rf_we_o;
    logic [7:0] rf_addr_o, rf_wdata_o, reg_rdata_o, imr_o, flags_o;
    logic [7:0] rf_mem [256];
    int         mismatches = 0;
    int         n_compared = 0;

    always #2.5 clk_i = ~clk_i;

    int_enable_and_increment_exec dut (
        .clk_i, .rst_n_i, .start_i, .opcode_i, .operand_i, .rp_i, .accept_o, .busy_o,
        .done_o, .rf_addr_o, .rf_re_o, .rf_we_o, .rf_wdata_o, .rf_rdata_i, .reg_addr_i,
        .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .imr_o, .flags_o
    );

    // Register file: data only in the cycle after a read strobe, churning otherwise
    always @(posedge clk_i) begin
        if (rf_we_o) rf_mem[rf_addr_o] <= rf_wdata_o;
        rf_rdata_i <= rf_re_o ? rf_mem[rf_addr_o] : ~rf_rdata_i;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Flags with carry, half-carry, decimal and bit 7 kept from 8'hcf
    function automatic logic [7:0] fl(input logic z, input logic s, input logic v);
        return {1'b1, z, s, v, 4'hf};
    endfunction : fl

    task automatic report_and_stop;
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_we_i    <= 1'b1;
        @(posedge clk_i);
        reg_we_i    <= 1'b0;
    endtask : reg_wr

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i   <= 1'b1;
        @(posedge clk_i);
        reg_re_i   <= 1'b0;
        #1 `CHK(reg_rdata_o, e)
    endtask : reg_chk

    // Issues one instruction, holds start one extra cycle to see it refused while busy
    task automatic run_op(input logic [7:0] op, input logic [7:0] opd, input logic [3:0] rp,
                          input int n);
        int k;
        @(posedge clk_i);
        start_i   <= 1'b1;
        opcode_i  <= op;
        operand_i <= opd;
        rp_i      <= rp;
        #1 `CHK(accept_o, 1'b1)
        @(posedge clk_i);
        #1 `CHK(accept_o, 1'b0)
        `CHK(busy_o, 1'b1)
        @(posedge clk_i);
        start_i <= 1'b0;
        for (k = 2; k < 20; k++) begin
            #1 if (done_o === 1'b1) break;
            @(posedge clk_i);
        end
        if (k == 20) begin
            mismatches++;
            report_and_stop();
        end
        `CHK(k, n - 1)
        // Let the last register-file write land before the caller looks
        @(posedge clk_i);
        #1 `CHK(done_o, 1'b0)
    endtask : run_op

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs;
        reg_chk(ADDR_INTERRUPT_GATE_MASK, IMR_RESET);
        reg_chk(ADDR_FLAGS, FLAGS_RESET);
        reg_wr(8'h10, 8'h55);
        reg_chk(8'h10, 8'h00);
    endtask : t_reset_regs

    task automatic t_unmask;
        reg_wr(ADDR_INTERRUPT_GATE_MASK, 8'h0a);
        reg_wr(ADDR_FLAGS, 8'hcf);
        run_op(OPC_GLOBAL_IRQ_UNMASK, 8'h00, 4'h0, 6);
        `CHK(imr_o, 8'h8a)
        `CHK(flags_o, 8'hcf)
        reg_chk(ADDR_INTERRUPT_GATE_MASK, 8'h8a);
    endtask : t_unmask

    task automatic t_byte_incs;
        rf_mem[8'h30] = 8'h7f;
        rf_mem[8'h35] = 8'hff;
        rf_mem[8'h42] = 8'h50;
        rf_mem[8'h50] = 8'h2a;
        run_op(OPC_INC_DIRECT, 8'h30, 4'h0, 6);
        `CHK(rf_mem[8'h30], 8'h80)
        `CHK(flags_o, fl(1'b0, 1'b1, 1'b1))
        run_op(8'h5e, 8'h00, 4'h3, 6);
        `CHK(rf_mem[8'h35], 8'h00)
        `CHK(flags_o, fl(1'b1, 1'b0, 1'b0))
        run_op(OPC_INC_POINTER, 8'he2, 4'h4, 6);
        `CHK(rf_mem[8'h50], 8'h2b)
        `CHK(flags_o, fl(1'b0, 1'b0, 1'b0))
    endtask : t_byte_incs

    task automatic t_pair_incs;
        rf_mem[8'h60] = 8'h7f;
        rf_mem[8'h61] = 8'hff;
        rf_mem[8'h74] = 8'h64;
        rf_mem[8'h64] = 8'hff;
        rf_mem[8'h65] = 8'hff;
        run_op(OPC_PAIR_DIRECT, 8'h60, 4'h0, 10);
        `CHK({rf_mem[8'h60], rf_mem[8'h61]}, 16'h8000)
        `CHK(flags_o, fl(1'b0, 1'b1, 1'b1))
        run_op(OPC_PAIR_POINTER, 8'he4, 4'h7, 10);
        `CHK({rf_mem[8'h64], rf_mem[8'h65]}, 16'h0000)
        `CHK(flags_o, fl(1'b1, 1'b0, 1'b0))
    endtask : t_pair_incs

    task automatic t_unknown_op;
        @(posedge clk_i);
        start_i  <= 1'b1;
        opcode_i <= 8'h00;
        #1 `CHK(accept_o, 1'b0)
        @(posedge clk_i);
        start_i <= 1'b0;
        #1 `CHK(busy_o, 1'b0)
    endtask : t_unknown_op

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset_regs();
        t_unmask();
        t_byte_incs();
        t_pair_incs();
        t_unknown_op();
        report_and_stop();
    end
endmodule : tb_int_enable_and_increment_exec
`default_nettype wire
